// ---- bench/jbe_prog_mem.sv ----
// Purpose: Program memory model that answers instruction fetches.
// Assumes: A byte is due in the cycle after each fetch request.
// Notes: The bench loads the array directly.
`timescale 1ns/100ps

module jbe_prog_mem (
  input wire logic clk,
  input wire logic fetchRd,
  input wire logic [15:0] fetchAddr,
  output logic [7:0] fetchData
);
  logic [7:0] mem [0:65535];

  initial fetchData = 8'h00;

  // Between fetches the bus shows the inverse, so a stale byte is never taken for an answer.
  always @(posedge clk) begin
    if (fetchRd) begin
      fetchData <= mem[fetchAddr];
    end else begin
      fetchData <= ~fetchData;
    end
  end
endmodule

// ---- bench/jump_branch_execution_tb.sv ----
// Purpose: Self-checking bench for the jump execution core.
// Assumes: Flags and source registers stay fixed for a whole program run.
// Notes: Each run builds a chain of jumps and expects one result per instruction.
`timescale 1ns/100ps
`include "jbe_defs.svh"

module jump_branch_execution_tb;
  logic clk, rst, fetchRd, flagWrite, jumpTaken, instrDone, otherOpcode;
  logic [7:0] flags, fetchData, otherOpcodeByte, fl;
  logic [15:0] pointerPair, firstIndexRegister, secondIndexRegister;
  logic [15:0] fetchAddr, programCounter, a, pp, ix, iy;
  // Each note holds other flag, other byte, taken flag and counter value.
  logic [25:0] expQ[$];
  logic [25:0] ex;
  int fails, cmp_count;

  jbe_core dut (.clk(clk), .rst(rst), .flags(flags), .pointerPair(pointerPair),
    .firstIndexRegister(firstIndexRegister), .secondIndexRegister(secondIndexRegister),
    .fetchData(fetchData), .fetchRd(fetchRd), .fetchAddr(fetchAddr),
    .programCounter(programCounter), .flagWrite(flagWrite), .jumpTaken(jumpTaken),
    .instrDone(instrDone), .otherOpcode(otherOpcode), .otherOpcodeByte(otherOpcodeByte));
  jbe_prog_mem pm (.clk(clk), .fetchRd(fetchRd), .fetchAddr(fetchAddr), .fetchData(fetchData));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic chk_pc(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: counter %h, wanted %h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: status bit %b, wanted %b", $time, got, exp);
    end
  endtask

  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: reported byte %h, wanted %h", $time, got, exp);
    end
  endtask

  function automatic logic cond(input logic [2:0] c, input logic [7:0] f);
    logic v;
    case (c[2:1])
      2'd0: v = f[`JBE_FLAG_ZERO];
      2'd1: v = f[`JBE_FLAG_CARRY];
      2'd2: v = f[`JBE_FLAG_PARITY];
      default: v = f[`JBE_FLAG_SIGN];
    endcase
    return v == c[0];
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Program builders: write bytes at the running address and note the outcome.
  task automatic absj(input logic [7:0] op, input logic tk, input logic [15:0] tgt);
    pm.mem[a] = op;
    pm.mem[a + 16'h1] = tgt[7:0];
    pm.mem[a + 16'h2] = tgt[15:8];
    a = tk ? tgt : a + 16'h3;
    expQ.push_back({1'b0, 8'h00, tk, a});
  endtask

  task automatic rel(input logic [7:0] op, input logic tk, input logic [7:0] e);
    pm.mem[a] = op;
    pm.mem[a + 16'h1] = e;
    a = tk ? a + 16'h2 + {{8{e[7]}}, e} : a + 16'h2;
    expQ.push_back({1'b0, 8'h00, tk, a});
  endtask

  task automatic ind(input logic [7:0] pre, input logic [15:0] r);
    if (pre != 8'h00) begin
      pm.mem[a] = pre;
      a = a + 16'h1;
    end
    pm.mem[a] = `JBE_OP_INDIRECT;
    a = r;
    expQ.push_back({1'b0, 8'h00, 1'b1, a});
  endtask

  // A byte the core does not execute is skipped as one byte and reported.
  task automatic oth(input logic [7:0] pre, input logic [7:0] op);
    if (pre != 8'h00) begin
      pm.mem[a] = pre;
      a = a + 16'h1;
    end
    pm.mem[a] = op;
    a = a + 16'h1;
    expQ.push_back({1'b1, op, 1'b0, a});
  endtask

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge clk) begin
    if (rst === 1'b0 && instrDone === 1'b1 && expQ.size() > 0) begin
      ex = expQ.pop_front();
      chk_pc(programCounter, ex[15:0]);
      chk_bit(jumpTaken, ex[16]);
      chk_bit(flagWrite, 1'b0);
      chk_bit(otherOpcode, ex[25]);
      if (ex[25]) begin
        chk_byte(otherOpcodeByte, ex[24:17]);
      end
    end
  end

  initial begin
    #(100 * 20000);
    fails++;
    close_out();
  end

  initial begin
    rst = 1'b1;
    flags = 8'h00;
    pointerPair = 16'h0000;
    firstIndexRegister = 16'h0000;
    secondIndexRegister = 16'h0000;
    fails = 0;
    cmp_count = 0;
    void'($urandom(32'h1bd0));
    for (int run = 0; run < 6; run++) begin
      @(posedge clk);
      rst <= 1'b1;
      @(posedge clk);
      for (int i = 0; i < 65536; i++) pm.mem[i] = 8'h00;
      fl = 8'($urandom);
      pp = 16'h6000 + 16'($urandom % 256);
      ix = 16'h7000 + 16'($urandom % 256);
      iy = 16'h7800 + 16'($urandom % 256);
      flags <= fl;
      pointerPair <= pp;
      firstIndexRegister <= ix;
      secondIndexRegister <= iy;
      a = 16'h0000;
      absj(`JBE_OP_ABS_UNCOND, 1'b1, 16'h4000);
      for (int c = 0; c < 8; c++) begin
        absj(8'(8'hc2 | (c << 3)), cond(3'(c), fl), 16'(a + 3 + $urandom % 64));
      end
      for (int c = 0; c < 4; c++) begin
        rel(8'(8'h20 | (c << 3)), cond(3'(c), fl), 8'($urandom % 128));
      end
      rel(`JBE_OP_REL_UNCOND, 1'b1, 8'h7f);
      rel(`JBE_OP_REL_UNCOND, 1'b1, 8'h80);
      oth(8'h00, 8'h40 | 8'($urandom % 32));
      oth(`JBE_OP_PREFIX_FIRST, `JBE_OP_ABS_UNCOND);
      ind(8'h00, pp);
      ind(`JBE_OP_PREFIX_FIRST, ix);
      ind(`JBE_OP_PREFIX_SECOND, iy);
      repeat (14) @(posedge clk);
      rst <= 1'b0;
      for (int k = 0; k < 600 && expQ.size() > 0; k++) @(posedge clk);
      if (expQ.size() != 0) begin
        fails++;
        $display("unexpected at %0t: %0d results missing", $time, expQ.size());
        expQ.delete();
      end
      $display("run %0d done", run);
    end
    close_out();
  end
endmodule

// ---- hdl/jbe_core.sv ----
// Purpose: Fetch, decode and execute the jump instructions of the core.
// Assumes: Program memory answers a fetch with data in the following cycle.
// Notes: Opcodes other than jumps and prefixes are reported and skipped as one byte.
`timescale 1ns/100ps
`include "jbe_defs.svh"

module jbe_core
  import jbe_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] flags,
  input wire logic [15:0] pointerPair,
  input wire logic [15:0] firstIndexRegister,
  input wire logic [15:0] secondIndexRegister,
  input wire logic [7:0] fetchData,
  output logic fetchRd,
  output logic [15:0] fetchAddr,
  output logic [15:0] programCounter,
  output logic flagWrite,
  output logic jumpTaken,
  output logic instrDone,
  output logic otherOpcode,
  output logic [7:0] otherOpcodeByte
);

  ////////////////////////////////////////////////////////////////////////////////
  jbe_state_e state_q;
  logic [15:0] progCnt_q;
  logic [7:0] opcode_q;
  logic [7:0] lowByte_q;
  logic byteCnt_q;
  logic prefixed_q;
  logic useSecond_q;
  logic jumpTaken_q;
  logic instrDone_q;
  logic otherOpcode_q;
  logic [7:0] otherByte_q;

  logic isIndirect;
  logic isAbsOp;
  logic isRelOp;
  logic finalByte;
  logic takeJump;
  logic [15:0] absTarget;
  logic [15:0] relTarget;
  logic [15:0] progCnt_d;

  // Condition field selects one flag; its low bit gives the level that passes.
  function automatic logic condition_field_true(input logic [2:0] ccc, input logic [7:0] f);
    logic bitVal;
    bitVal = 1'b0;
    case (ccc[2:1])
      2'b00: bitVal = f[`JBE_FLAG_ZERO];
      2'b01: bitVal = f[`JBE_FLAG_CARRY];
      2'b10: bitVal = f[`JBE_FLAG_PARITY];
      2'b11: bitVal = f[`JBE_FLAG_SIGN];
      default: bitVal = 1'b0;
    endcase
    return bitVal == ccc[0];
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  assign fetchRd = (state_q == JBE_FETCH) || (state_q == JBE_OPREQ);
  assign fetchAddr = progCnt_q;
  assign programCounter = progCnt_q;
  assign jumpTaken = jumpTaken_q;
  assign instrDone = instrDone_q;
  assign otherOpcode = otherOpcode_q;
  assign otherOpcodeByte = otherByte_q;
  assign flagWrite = 1'b0;

  assign isIndirect = fetchData == `JBE_OP_INDIRECT;
  assign isAbsOp = (opcode_q == `JBE_OP_ABS_UNCOND) ||
                   ((opcode_q & `JBE_ABS_COND_MASK) == `JBE_ABS_COND_CODE);
  assign isRelOp = !isAbsOp;
  assign finalByte = isRelOp || byteCnt_q;
  assign absTarget = {fetchData, lowByte_q};
  assign relTarget = progCnt_q + 16'h0001 + {{8{fetchData[7]}}, fetchData};

  always_comb begin
    takeJump = 1'b1;
    if (opcode_q == `JBE_OP_ABS_UNCOND || opcode_q == `JBE_OP_REL_UNCOND) begin
      takeJump = 1'b1;
    end else if (isAbsOp) begin
      takeJump = condition_field_true(opcode_q[5:3], flags);
    end else begin
      takeJump = condition_field_true({1'b0, opcode_q[4:3]}, flags);
    end
  end

  always_comb begin
    progCnt_d = progCnt_q + 16'h0001;
    if (state_q == JBE_OPDATA && finalByte && takeJump) begin
      progCnt_d = isAbsOp ? absTarget : relTarget;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q <= JBE_FETCH;
    end else begin
      case (state_q)
        JBE_FETCH: state_q <= JBE_DECODE;
        JBE_DECODE: begin
          if (!prefixed_q && (fetchData == `JBE_OP_ABS_UNCOND ||
              fetchData == `JBE_OP_REL_UNCOND ||
              (fetchData & `JBE_ABS_COND_MASK) == `JBE_ABS_COND_CODE ||
              (fetchData & `JBE_REL_COND_MASK) == `JBE_REL_COND_CODE)) begin
            state_q <= JBE_OPREQ;
          end else begin
            state_q <= JBE_FETCH;
          end
        end
        JBE_OPREQ: state_q <= JBE_OPDATA;
        JBE_OPDATA: state_q <= finalByte ? JBE_FETCH : JBE_OPREQ;
        default: state_q <= JBE_FETCH;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      progCnt_q <= `JBE_COUNTER_RESET;
    end else if (state_q == JBE_DECODE) begin
      if (isIndirect && !prefixed_q) begin
        progCnt_q <= pointerPair;
      end else if (isIndirect) begin
        progCnt_q <= useSecond_q ? secondIndexRegister : firstIndexRegister;
      end else begin
        progCnt_q <= progCnt_q + 16'h0001;
      end
    end else if (state_q == JBE_OPDATA) begin
      progCnt_q <= progCnt_d;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prefixed_q <= 1'b0;
      useSecond_q <= 1'b0;
    end else if (state_q == JBE_DECODE) begin
      prefixed_q <= !prefixed_q && (fetchData == `JBE_OP_PREFIX_FIRST ||
                                    fetchData == `JBE_OP_PREFIX_SECOND);
      useSecond_q <= fetchData == `JBE_OP_PREFIX_SECOND;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      opcode_q <= 8'h00;
      lowByte_q <= 8'h00;
      byteCnt_q <= 1'b0;
    end else if (state_q == JBE_DECODE) begin
      opcode_q <= fetchData;
      byteCnt_q <= 1'b0;
    end else if (state_q == JBE_OPDATA) begin
      lowByte_q <= fetchData;
      byteCnt_q <= 1'b1;
    end
  end

  // A byte that follows a prefix and is not the indirect opcode is handed on as other.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      jumpTaken_q <= 1'b0;
      instrDone_q <= 1'b0;
      otherOpcode_q <= 1'b0;
      otherByte_q <= 8'h00;
    end else begin
      jumpTaken_q <= 1'b0;
      instrDone_q <= 1'b0;
      otherOpcode_q <= 1'b0;
      if (state_q == JBE_DECODE) begin
        if (isIndirect) begin
          jumpTaken_q <= 1'b1;
          instrDone_q <= 1'b1;
        end else if (prefixed_q || (fetchData != `JBE_OP_PREFIX_FIRST &&
                     fetchData != `JBE_OP_PREFIX_SECOND &&
                     fetchData != `JBE_OP_ABS_UNCOND &&
                     fetchData != `JBE_OP_REL_UNCOND &&
                     (fetchData & `JBE_ABS_COND_MASK) != `JBE_ABS_COND_CODE &&
                     (fetchData & `JBE_REL_COND_MASK) != `JBE_REL_COND_CODE)) begin
          otherOpcode_q <= 1'b1;
          otherByte_q <= fetchData;
          instrDone_q <= 1'b1;
        end
      end else if (state_q == JBE_OPDATA && finalByte) begin
        jumpTaken_q <= takeJump;
        instrDone_q <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // pointer pair check
  indirect_pair_a: assert property (@(posedge clk) disable iff (rst)
    state_q == JBE_DECODE && !prefixed_q && fetchData == `JBE_OP_INDIRECT
    |=> progCnt_q == $past(pointerPair) && state_q == JBE_FETCH && fetchRd)
    else $error("indirect jump did not load pointer pair");

  index_source_a: assert property (@(posedge clk) disable iff (rst)
    state_q == JBE_DECODE && prefixed_q && fetchData == `JBE_OP_INDIRECT
    |=> progCnt_q == ($past(useSecond_q) ? $past(secondIndexRegister) :
                      $past(firstIndexRegister)))
    else $error("indexed jump loaded wrong register");

  other_prefix_a: assert property (@(posedge clk) disable iff (rst)
    state_q == JBE_DECODE && prefixed_q && fetchData != `JBE_OP_INDIRECT
    |=> otherOpcode_q && !jumpTaken_q && otherByte_q == $past(fetchData))
    else $error("prefixed byte not reported as other opcode");

  abs_taken_a: assert property (@(posedge clk) disable iff (rst)
    state_q == JBE_OPDATA && isAbsOp && byteCnt_q && takeJump
    |=> progCnt_q == {$past(fetchData), $past(lowByte_q)} && fetchRd && jumpTaken_q)
    else $error("absolute jump target not loaded");

  cond_false_a: assert property (@(posedge clk) disable iff (rst)
    state_q == JBE_OPDATA && finalByte && !takeJump
    |=> progCnt_q == $past(progCnt_q) + 16'h0001 && !jumpTaken_q && instrDone_q)
    else $error("false condition did not skip instruction");

  cond_parity_a: assert property (@(posedge clk) disable iff (rst)
    state_q == JBE_OPDATA && opcode_q == 8'he2
    |-> takeJump == !flags[`JBE_FLAG_PARITY])
    else $error("parity odd condition wrong");

  cond_sign_a: assert property (@(posedge clk) disable iff (rst)
    state_q == JBE_OPDATA && opcode_q == 8'hfa
    |-> takeJump == flags[`JBE_FLAG_SIGN])
    else $error("sign negative condition wrong");

  cond_zero_a: assert property (@(posedge clk) disable iff (rst)
    state_q == JBE_OPDATA && opcode_q == 8'hc2 && flags[`JBE_FLAG_ZERO]
    |-> !takeJump)
    else $error("not zero condition passed with zero set");

  rel_taken_a: assert property (@(posedge clk) disable iff (rst)
    state_q == JBE_OPDATA && isRelOp && takeJump
    |=> progCnt_q == $past(progCnt_q) + 16'h0001 +
        {{8{$past(fetchData[7])}}, $past(fetchData)})
    else $error("relative jump landed wrong");

  rel_range_a: assert property (@(posedge clk) disable iff (rst)
    state_q == JBE_OPDATA && isRelOp && takeJump && fetchData == 8'h80
    |=> progCnt_q == $past(progCnt_q) - 16'h007f)
    else $error("relative base not advanced counter");

  rel_nonzero_a: assert property (@(posedge clk) disable iff (rst)
    state_q == JBE_OPDATA && opcode_q == 8'h20
    |-> takeJump == !flags[`JBE_FLAG_ZERO])
    else $error("relative not zero condition wrong");

  rel_carry_a: assert property (@(posedge clk) disable iff (rst)
    state_q == JBE_OPDATA && opcode_q == 8'h38
    |-> takeJump == flags[`JBE_FLAG_CARRY])
    else $error("relative carry condition wrong");

  rel_always_a: assert property (@(posedge clk) disable iff (rst)
    state_q == JBE_OPDATA && opcode_q == `JBE_OP_REL_UNCOND |=> jumpTaken_q)
    else $error("unconditional relative jump not taken");

  flags_kept_a: assert property (@(posedge clk) disable iff (rst)
    instrDone_q |-> !flagWrite)
    else $error("jump wrote flags");

  abs_always_a: assert property (@(posedge clk) disable iff (rst)
    state_q == JBE_OPDATA && opcode_q == `JBE_OP_ABS_UNCOND && byteCnt_q
    |=> jumpTaken_q && progCnt_q == {$past(fetchData), $past(lowByte_q)})
    else $error("unconditional absolute jump not taken");

endmodule

// ---- hdl/jbe_defs.svh ----
// Purpose: Constants of the jump execution block.
// Assumes: Included by the core and the bench.
// Notes: Flag bit positions follow the usual flag register layout.
`ifndef JBE_DEFS_SVH
`define JBE_DEFS_SVH

`define JBE_COUNTER_RESET 16'h0000
`define JBE_OP_INDIRECT 8'he9
`define JBE_OP_PREFIX_FIRST 8'hdd
`define JBE_OP_PREFIX_SECOND 8'hfd
`define JBE_OP_ABS_UNCOND 8'hc3
`define JBE_OP_REL_UNCOND 8'h18
`define JBE_ABS_COND_MASK 8'hc7
`define JBE_ABS_COND_CODE 8'hc2
`define JBE_REL_COND_MASK 8'he7
`define JBE_REL_COND_CODE 8'h20
`define JBE_FLAG_SIGN 7
`define JBE_FLAG_ZERO 6
`define JBE_FLAG_PARITY 2
`define JBE_FLAG_CARRY 0

`endif

// ---- hdl/jbe_pkg.sv ----
// Purpose: Types of the jump execution block.
// Assumes: Nothing beyond the constants header.
// Notes: States are one-hot.
package jbe_pkg;
  typedef enum logic [3:0] {
    JBE_FETCH = 4'b0001,
    JBE_DECODE = 4'b0010,
    JBE_OPREQ = 4'b0100,
    JBE_OPDATA = 4'b1000
  } jbe_state_e;
endpackage
